// *** rtl/ldf_dimming_ctrl.v ***
/*
 * LED dimming, fail-safe takeover and converter handshake control for a
 * 24-channel output stage, with an Avalon-MM register slave.
 * Assumes all inputs synchronous to clk_sys_in; nonvolatile defaults arrive as
 * static input buses; the analog converter answers start with a done pulse.
 */
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "ldf_defines.vh"

module ldf_dimming_ctrl #(
    parameter             NCH           = 24,
    parameter             EXP_LUT_VALID = 0,
    parameter [3071:0]    EXP_LUT       = 3072'h0
) (
    // clock and reset
    input  wire           clk_sys_in,
    input  wire           resetn_in,
    // avalon-mm slave
    input  wire [8:0]     avs_address_in,
    input  wire           avs_read_in,
    input  wire           avs_write_in,
    input  wire [31:0]    avs_writedata_in,
    input  wire [3:0]     avs_byteenable_in,
    output reg  [31:0]    avs_readdata_out,
    output wire           avs_waitrequest_out,
    // nonvolatile defaults
    input  wire           nvm_exp_curve_select_in,
    input  wire [3:0]     nvm_dimming_frequency_field_in,
    input  wire [191:0]   nvm_duty_high_byte_in,
    input  wire [95:0]    nvm_duty_low_nibble_in,
    input  wire [143:0]   nvm_channel_current_step_in,
    input  wire [23:0]    nvm_channel_output_enable_in,
    input  wire [23:0]    nvm_failsafe_input_map_in,
    // fail-safe and fault
    input  wire           failsafe_active_in,
    input  wire           failsafe_input_a_in,
    input  wire           failsafe_input_b_in,
    input  wire           fault_event_in,
    output reg            fault_pin_out,
    output reg            low_current_mode_out,
    // channel outputs
    output wire [287:0]   channel_duty_out,
    output wire [23:0]    channel_full_on_out,
    output wire [23:0]    channel_output_on_out,
    output wire [143:0]   channel_current_step_out,
    output wire [3:0]     dimming_frequency_field_out,
    output wire           phase_shift_select_out,
    // converter handshake
    output reg            conv_start_out,
    output reg  [4:0]     conv_channel_out,
    input  wire           conv_done_in,
    input  wire [7:0]     conv_result_in
);

    localparam CV_IDLE  = 2'd0;
    localparam CV_WAIT  = 2'd1;
    localparam CV_SCAN  = 2'd2;
    localparam CV_SWAIT = 2'd3;

    reg           ack;
    reg           boot_pending;
    reg           fs_q;
    reg           exp_sel;
    reg           res12;
    reg           shared_sel;
    reg           phase_sel;
    reg  [3:0]    freq;
    reg           one_all;
    reg  [23:0]   enables;
    reg  [23:0]   fs_map;
    reg  [4:0]    conv_sel;
    reg  [7:0]    conv_result;
    reg           conv_done;
    reg           conv_pend;
    reg  [1:0]    cv_state;
    reg  [4:0]    scan_idx;
    reg  [7:0]    scan_max;
    reg  [31:0]   rd_mux;

    wire [191:0]  high_flat;
    wire [95:0]   low_flat;
    wire [12:0]   ap_first;
    wire          req      = avs_read_in | avs_write_in;
    wire          wr_go    = avs_write_in & ack;
    wire          rd_go    = avs_read_in & ack;
    wire          fs_entry = failsafe_active_in & ~fs_q;
    wire [4:0]    idx      = avs_address_in[6:2];
    wire [23:0]   sel_hot  = 24'h000001 << idx;
    wire          in_chan  = (avs_address_in[8:7] != 2'h3) && (idx < `LDF_NUM_CHANNELS);
    wire [31:0]   bmask    = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                              {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    wire [31:0]   wv       = (avs_writedata_in & bmask) | (rd_mux & ~bmask);
    wire          wr_cfg   = wr_go && (avs_address_in == `LDF_ADDR_CONFIG);
    wire          wr_sel   = wr_go && (avs_address_in == `LDF_ADDR_CONV_SEL);
    wire          rd_res   = rd_go && (avs_address_in == `LDF_ADDR_CONV_RESULT);
    wire          shared_clear = wr_cfg & shared_sel & ~wv[`LDF_CFG_SHARED];

    // duty code from the duty registers; bit 12 marks fully on
    function [12:0] ldf_duty_code;
        input [7:0] h;
        input [3:0] l;
        input       e;
        input       r;
        reg   [12:0] t;
        begin
            t = {7'h00, 1'b1, h[4:0]} << h[7:5];
            if (e) begin
                if (EXP_LUT_VALID != 0)
                    ldf_duty_code = {(h == 8'hFF), EXP_LUT[h*12 +: 12]};
                else
                    ldf_duty_code = {(h == 8'hFF), t[12:1] - 12'h010};
            end else if (r) begin
                ldf_duty_code = {(h == 8'hFF) && (l == 4'hF), h, l};
            end else begin
                ldf_duty_code = {(h == 8'hFF), h, 4'h0};
            end
        end
    endfunction

    // avalon handshake: one wait state, request completes at the second edge
    assign avs_waitrequest_out = req & ~ack;

    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack              <= 1'b0;
            avs_readdata_out <= 32'h00000000;
        end else begin
            ack <= req & ~ack;
            if (avs_read_in & ~ack)
                avs_readdata_out <= rd_mux;
        end
    end

    // read-back mux, also feeds byte-lane merging on writes
    always @* begin
        rd_mux = 32'h00000000;
        if (in_chan) begin
            case (avs_address_in[8:7])
                `LDF_REGION_DUTY_HIGH: rd_mux[7:0] = high_flat[idx*8 +: 8];
                `LDF_REGION_DUTY_LOW:  rd_mux[3:0] = low_flat[idx*4 +: 4];
                default:               rd_mux[5:0] = channel_current_step_out[idx*6 +: 6];
            endcase
        end else begin
            case (avs_address_in)
                `LDF_ADDR_ENABLE:      rd_mux[23:0] = enables;
                `LDF_ADDR_FS_MAP:      rd_mux[23:0] = fs_map;
                `LDF_ADDR_CONFIG:      rd_mux[8:0]  = {one_all, freq, phase_sel, shared_sel, res12, exp_sel};
                `LDF_ADDR_CONV_SEL:    rd_mux[4:0]  = conv_sel;
                `LDF_ADDR_CONV_RESULT: rd_mux[7:0]  = conv_result;
                `LDF_ADDR_STATUS:      rd_mux[4:0]  = {low_current_mode_out, failsafe_active_in,
                                                       failsafe_input_b_in, failsafe_input_a_in,
                                                       conv_done};
                default:               rd_mux = 32'h00000000;
            endcase
        end
    end

    // global configuration, enables, map, fail-safe reload and fault mode
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            boot_pending         <= 1'b1;
            fs_q                 <= 1'b0;
            exp_sel              <= 1'b0;
            res12                <= `LDF_RST_RES12;
            shared_sel           <= 1'b0;
            phase_sel            <= 1'b0;
            freq                 <= `LDF_RST_FREQ;
            one_all              <= 1'b0;
            enables              <= 24'h000000;
            fs_map               <= 24'h000000;
            low_current_mode_out <= 1'b0;
            fault_pin_out        <= 1'b0;
        end else begin
            fs_q         <= failsafe_active_in;
            boot_pending <= 1'b0;
            if (boot_pending | fs_entry) begin
                exp_sel <= nvm_exp_curve_select_in;
                freq    <= nvm_dimming_frequency_field_in;
            end else if (wr_cfg) begin
                exp_sel <= wv[`LDF_CFG_EXP];
                freq    <= wv[`LDF_CFG_FREQ_LSB +: 4];
            end
            if (fs_entry) begin
                enables <= nvm_channel_output_enable_in;
                fs_map  <= nvm_failsafe_input_map_in;
            end else begin
                if (wr_go && (avs_address_in == `LDF_ADDR_ENABLE))
                    enables <= wv[23:0];
                if (wr_go && (avs_address_in == `LDF_ADDR_FS_MAP))
                    fs_map <= wv[23:0];
            end
            if (wr_cfg) begin
                res12      <= wv[`LDF_CFG_RES12];
                shared_sel <= wv[`LDF_CFG_SHARED];
                phase_sel  <= wv[`LDF_CFG_PHASE];
                one_all    <= wv[`LDF_CFG_ONE_ALL];
            end
            // fault mode latches until reset
            if (one_all & fault_event_in)
                low_current_mode_out <= 1'b1;
            fault_pin_out <= fault_event_in | low_current_mode_out;
        end
    end

    assign dimming_frequency_field_out = freq;
    assign phase_shift_select_out      = phase_sel;

    // per-channel duty, current and output state
    genvar n;
    generate
        for (n = 0; n < NCH; n = n + 1) begin : g_ch
            reg  [7:0]  high;
            reg  [3:0]  low;
            reg  [5:0]  cur;
            reg  [12:0] ap;
            reg  [12:0] duty_q;
            reg         on_q;
            wire        hit = in_chan & sel_hot[n];

            always @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    high   <= 8'h00;
                    low    <= 4'h0;
                    cur    <= `LDF_RST_CURRENT;
                    ap     <= 13'h0000;
                    duty_q <= 13'h0000;
                    on_q   <= 1'b0;
                end else begin
                    if (fs_entry) begin
                        high <= nvm_duty_high_byte_in[n*8 +: 8];
                        low  <= nvm_duty_low_nibble_in[n*4 +: 4];
                        cur  <= nvm_channel_current_step_in[n*6 +: 6];
                        ap   <= ldf_duty_code(nvm_duty_high_byte_in[n*8 +: 8],
                                              nvm_duty_low_nibble_in[n*4 +: 4],
                                              nvm_exp_curve_select_in, res12);
                    end else begin
                        if (wr_go && hit && (avs_address_in[8:7] == `LDF_REGION_DUTY_HIGH)) begin
                            high <= wv[7:0];
                            ap   <= ldf_duty_code(wv[7:0], low, exp_sel, res12);
                        end else if (shared_clear) begin
                            ap <= ap_first;
                        end
                        if (wr_go && hit && (avs_address_in[8:7] == `LDF_REGION_DUTY_LOW))
                            low <= wv[3:0];
                        if (wr_go && hit && (avs_address_in[8:7] == `LDF_REGION_CURRENT))
                            cur <= wv[5:0];
                    end
                    duty_q <= shared_sel ? ap_first : ap;
                    if (failsafe_active_in)
                        on_q <= fs_map[n] ? failsafe_input_b_in : failsafe_input_a_in;
                    else
                        on_q <= enables[n];
                end
            end

            assign high_flat[n*8 +: 8]                = high;
            assign low_flat[n*4 +: 4]                 = low;
            assign channel_current_step_out[n*6 +: 6] = cur;
            assign channel_duty_out[n*12 +: 12]       = duty_q[11:0];
            assign channel_full_on_out[n]             = duty_q[12];
            assign channel_output_on_out[n]           = on_q;
            if (n == 0) begin : g_first
                assign ap_first = ap;
            end
        end
    endgenerate

    // converter control: manual, reserved and max-output scan
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            conv_sel         <= 5'h00;
            conv_result      <= 8'h00;
            conv_done        <= 1'b0;
            conv_pend        <= 1'b0;
            cv_state         <= CV_IDLE;
            scan_idx         <= 5'h00;
            scan_max         <= 8'h00;
            conv_start_out   <= 1'b0;
            conv_channel_out <= 5'h00;
        end else begin
            conv_start_out <= 1'b0;
            if (wr_sel)
                conv_sel <= wv[4:0];
            if (wr_sel | rd_res)
                conv_pend <= 1'b1;
            case (cv_state)
                CV_IDLE: begin
                    if (conv_pend & ~wr_sel & ~rd_res) begin
                        conv_pend <= 1'b0;
                        conv_done <= 1'b0;
                        if (conv_sel == `LDF_CONV_RESERVED) begin
                            conv_result <= 8'h00;
                            conv_done   <= 1'b1;
                        end else if (conv_sel == `LDF_CONV_MAX_OUTPUT_VOLTAGE_CHANNEL) begin
                            scan_idx <= 5'h00;
                            scan_max <= 8'h00;
                            cv_state <= CV_SCAN;
                        end else begin
                            conv_start_out   <= 1'b1;
                            conv_channel_out <= conv_sel;
                            cv_state         <= CV_WAIT;
                        end
                    end
                end
                CV_WAIT: begin
                    if (conv_done_in) begin
                        conv_result <= conv_result_in;
                        conv_done   <= 1'b1;
                        cv_state    <= CV_IDLE;
                    end
                end
                CV_SCAN: begin
                    if (scan_idx == `LDF_NUM_CHANNELS) begin
                        conv_result <= scan_max;
                        conv_done   <= 1'b1;
                        cv_state    <= CV_IDLE;
                    end else if (enables[scan_idx]) begin
                        conv_start_out   <= 1'b1;
                        conv_channel_out <= `LDF_CONV_FIRST_OUT + scan_idx;
                        cv_state         <= CV_SWAIT;
                    end else begin
                        scan_idx <= scan_idx + 5'h01;        // disabled channels skipped
                    end
                end
                CV_SWAIT: begin
                    if (conv_done_in) begin
                        if (conv_result_in > scan_max)
                            scan_max <= conv_result_in;
                        scan_idx <= scan_idx + 5'h01;
                        cv_state <= CV_SCAN;
                    end
                end
                default: cv_state <= CV_IDLE;
            endcase
        end
    end

endmodule // ldf_dimming_ctrl

// *** shared/ldf_defines.vh ***
/*
 * Register map, field positions, reset values and codes of the LED dimming,
 * fail-safe and converter control block.
 * Assumes 32-bit Avalon-MM byte addresses and a single 100 MHz system clock.
 */
`ifndef LDF_DEFINES_VH
`define LDF_DEFINES_VH

// region codes (address bits 8:7) and byte addresses
`define LDF_REGION_DUTY_HIGH   2'h0
`define LDF_REGION_DUTY_LOW    2'h1
`define LDF_REGION_CURRENT     2'h2
`define LDF_ADDR_ENABLE        9'h180
`define LDF_ADDR_FS_MAP        9'h184
`define LDF_ADDR_CONFIG        9'h188
`define LDF_ADDR_CONV_SEL      9'h18C
`define LDF_ADDR_CONV_RESULT   9'h190
`define LDF_ADDR_STATUS        9'h194

// config fields
`define LDF_CFG_EXP            0
`define LDF_CFG_RES12          1
`define LDF_CFG_SHARED         2
`define LDF_CFG_PHASE          3
`define LDF_CFG_FREQ_LSB       4
`define LDF_CFG_ONE_ALL        8

// status fields
`define LDF_ST_DONE            0
`define LDF_ST_FS_A            1
`define LDF_ST_FS_B            2
`define LDF_ST_FAILSAFE        3
`define LDF_ST_LOWCUR          4

// reset values
`define LDF_RST_RES12          1'b1
`define LDF_RST_FREQ           4'h0
`define LDF_RST_CURRENT        6'h00

// converter codes and channel count
`define LDF_CONV_MAX_OUTPUT_VOLTAGE_CHANNEL        5'h06
`define LDF_CONV_RESERVED      5'h07
`define LDF_CONV_FIRST_OUT     5'h08
`define LDF_NUM_CHANNELS       5'h18

`endif

// *** verif/ldf_conv_model.sv ***
/* converter model that answers the block's start pulses with a done pulse.
   assumes one start at a time; slow_in picks a long or short conversion. */
`timescale 1ns/100ps
module ldf_conv_model (
    // clock, reset and pace
    input  wire       clk_sys_in,
    input  wire       resetn_in,
    input  wire       slow_in,
    // converter handshake
    input  wire       conv_start_in,
    input  wire [4:0] conv_channel_in,
    output reg        conv_done_out,
    output reg  [7:0] conv_result_out
);
    reg [3:0] wait_cnt;
    reg       busy;
    reg [4:0] chan;
    // one done pulse per start; result differs per code, then turns stale
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            chan <= 5'h00;
            conv_done_out <= 1'b0;
            conv_result_out <= 8'h00;
        end else begin
            conv_done_out <= 1'b0;
            if (conv_start_in) begin
                busy <= 1'b1;
                chan <= conv_channel_in;
                wait_cnt <= slow_in ? 4'h9 : 4'h2;
            end else if (busy && wait_cnt == 4'h0) begin
                busy <= 1'b0;
                conv_done_out <= 1'b1;
                conv_result_out <= {3'h5, chan};
            end else if (busy) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (conv_done_out) begin
                conv_result_out <= ~conv_result_out; // data no longer held
            end
        end
    end
endmodule // ldf_conv_model

// *** verif/ldf_dimming_ctrl_props_props.sv ***
/* port checker for the dimming, fail-safe and converter control block.
   assumes it is bound onto the block's top module. */
`timescale 1ns/100ps
module ldf_dimming_ctrl_props (
    // watched ports
    input wire        clk_sys_in,
    input wire        resetn_in,
    input wire [8:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    input wire        failsafe_active_in,
    input wire        failsafe_input_a_in,
    input wire        failsafe_input_b_in,
    input wire        fault_event_in,
    input wire        fault_pin_out,
    input wire        low_current_mode_out,
    input wire [23:0] channel_output_on_out,
    input wire        conv_start_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    // completing read of the status word
    wire st_rd = avs_read_in && !avs_waitrequest_out && avs_address_in == 9'h194;
    wire sel_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == 9'h18C;
    // bus handshake
    wait_once_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus held more than one wait state");
    idle_nowait_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("wait state without request");
    // converter start
    start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
        else $error("start longer than one cycle");
    sel_start_a: assert property (sel_wr && avs_writedata_in[4:0] != 5'h07 |-> ##[1:40] conv_start_out)
        else $error("select write did not start a conversion");
    // fail-safe pins and flags
    fs_flag_a: assert property (st_rd |-> avs_readdata_out[2:1] == {$past(failsafe_input_b_in), $past(failsafe_input_a_in)})
        else $error("fail-safe level flags wrong");
    fs_on_a: assert property (failsafe_active_in && failsafe_input_a_in && failsafe_input_b_in |=> &channel_output_on_out)
        else $error("outputs not all on");
    fs_off_a: assert property (failsafe_active_in && !failsafe_input_a_in && !failsafe_input_b_in |=> channel_output_on_out == 24'h000000)
        else $error("outputs not all off");
    // fault indication
    fault_pin_a: assert property (fault_event_in |=> fault_pin_out)
        else $error("fault pin missed a fault");
    lowcur_hold_a: assert property (low_current_mode_out |=> low_current_mode_out)
        else $error("low-current mode dropped");
    cv_start_c: cover property (conv_start_out);
    cv_fs_c: cover property (failsafe_active_in && &channel_output_on_out);
    cv_low_c: cover property (low_current_mode_out);
endmodule // ldf_dimming_ctrl_props

// *** verif/test_led_dimming_failsafe_adc_ctrl.sv ***
/* self-checking bench for the dimming, fail-safe and converter control block.
   assumes the converter model on the far side and the checker bound below. */
`timescale 1ns/100ps
module test_led_dimming_failsafe_adc_ctrl;
    // clock, reset, bus and pins
    logic         clk_sys_in = 1'b0, resetn_in = 1'b0, rd = 1'b0, wr = 1'b0, slow = 1'b0;
    logic [8:0]   address = 9'h000;
    logic [31:0]  wdata = 32'h0, q;
    logic [3:0]   byteen = 4'hF;
    logic         fs_act = 1'b0, fs_a = 1'b0, fs_b = 1'b0, fault = 1'b0;
    wire  [31:0]  rdata;
    wire  [287:0] duty_w;
    wire  [143:0] cur_w;
    wire  [23:0]  full_w, on_w;
    wire  [3:0]   freq_w;
    wire  [7:0]   cres;
    wire  [4:0]   cch;
    wire          waitreq, fpin, lowcur, phase, cstart, cdone;
    int           err_total = 0, samples_checked = 0, i;
    logic [7:0]   codes [5] = '{8'h00, 8'h05, 8'h07, 8'h08, 8'h1F};
    logic [7:0]   exps [5] = '{8'hA0, 8'hA5, 8'h00, 8'hA8, 8'hBF};
    // design and converter model
    ldf_dimming_ctrl dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .avs_address_in(address),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(byteen),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .nvm_exp_curve_select_in(1'b1),
        .nvm_dimming_frequency_field_in(4'h9), .nvm_duty_high_byte_in({24{8'h3C}}),
        .nvm_duty_low_nibble_in({24{4'h5}}), .nvm_channel_current_step_in({24{6'h2A}}),
        .nvm_channel_output_enable_in(24'h00F0F0), .nvm_failsafe_input_map_in(24'h0000FF),
        .failsafe_active_in(fs_act), .failsafe_input_a_in(fs_a), .failsafe_input_b_in(fs_b),
        .fault_event_in(fault), .fault_pin_out(fpin), .low_current_mode_out(lowcur),
        .channel_duty_out(duty_w), .channel_full_on_out(full_w), .channel_output_on_out(on_w),
        .channel_current_step_out(cur_w), .dimming_frequency_field_out(freq_w),
        .phase_shift_select_out(phase), .conv_start_out(cstart), .conv_channel_out(cch),
        .conv_done_in(cdone), .conv_result_in(cres));
    ldf_conv_model u_conv (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .slow_in(slow),
        .conv_start_in(cstart), .conv_channel_in(cch), .conv_done_out(cdone), .conv_result_out(cres));
    // clock
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // compare, count and report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one bus transfer: held until waitrequest is low at a rising edge
    task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_sys_in);
        address <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        // waitrequest is sampled at each rising edge; the low one completes the transfer
        do
            @(posedge clk_sys_in);
        while (waitreq !== 1'b0);
        r = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (2) @(negedge clk_sys_in);
    endtask
    // poll the done flag under a bound
    task automatic wait_done;
        logic [31:0] s;
        s = 32'h0;
        for (int n = 0; n < 60 && s[0] !== 1'b1; n++) bus(1'b0, 9'h194, 32'h0, s);
        check("done flag", s[0], 32'h1);
    endtask
    // drive the fail-safe pins
    task automatic pins(input logic act, input logic a, input logic b, input logic f);
        @(posedge clk_sys_in);
        fs_act <= act;
        fs_a <= a;
        fs_b <= b;
        fault <= f;
        repeat (2) @(negedge clk_sys_in);
    endtask
    // verdict
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #400000;
        err_total++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        @(negedge clk_sys_in);
        check("duty ch5", duty_w[60 +: 12], 32'h0);
        bus(1'b0, 9'h188, 32'h0, q);
        check("config", q[7:0], 32'h93);
        check("freq", freq_w, 32'h9);
        bus(1'b1, 9'h188, 32'h2, q);
        bus(1'b1, 9'h094, 32'hA, q);
        check("duty low only", duty_w[60 +: 12], 32'h0);
        bus(1'b1, 9'h014, 32'h7B, q);
        check("duty 12b", duty_w[60 +: 12], 32'h7BA);
        bus(1'b1, 9'h094, 32'hF, q);
        bus(1'b1, 9'h014, 32'hFF, q);
        check("full 12b", full_w[5], 32'h1);
        bus(1'b1, 9'h188, 32'h0, q);
        bus(1'b1, 9'h014, 32'h40, q);
        check("duty 8b", {full_w[5], duty_w[60 +: 12]}, 32'h400);
        bus(1'b1, 9'h188, 32'h1, q);
        bus(1'b1, 9'h014, 32'h21, q);
        check("duty exp", duty_w[60 +: 12], 32'h011);
        bus(1'b1, 9'h014, 32'hFF, q);
        check("full exp", full_w[5], 32'h1);
        bus(1'b1, 9'h188, 32'h6, q);
        bus(1'b1, 9'h000, 32'h55, q);
        check("shared ch23", duty_w[276 +: 12], 32'h550);
        bus(1'b1, 9'h188, 32'h2, q);
        check("unshared ch7", duty_w[84 +: 12], 32'h550);
        bus(1'b1, 9'h01C, 32'h11, q);
        check("own ch7", duty_w[84 +: 12], 32'h110);
        bus(1'b1, 9'h180, 32'h24, q);
        bus(1'b1, 9'h108, 32'h15, q);
        check("enables", on_w, 32'h24);
        check("current ch2", cur_w[12 +: 6], 32'h15);
        repeat (20) @(posedge clk_sys_in);
        for (i = 0; i < 5; i++) begin
            if (i > 0) wait_done(); // restart from the last result read finishes first
            slow <= !i[0];
            bus(1'b1, 9'h18C, {24'h0, codes[i]}, q);
            wait_done();
            bus(1'b0, 9'h190, 32'h0, q);
            check("result", q[7:0], exps[i]);
        end
        bus(1'b0, 9'h194, 32'h0, q);
        check("done cleared", q[0], 32'h0);
        wait_done();
        bus(1'b0, 9'h190, 32'h0, q);
        check("result again", q[7:0], 32'hBF);
        wait_done();
        bus(1'b1, 9'h18C, 32'h06, q);
        wait_done();
        bus(1'b0, 9'h190, 32'h0, q);
        check("max out", q[7:0], 32'hAD);
        wait_done();
        pins(1'b1, 1'b1, 1'b1, 1'b0);
        check("fs all on", on_w, 32'hFFFFFF);
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        check("fs map a", on_w, 32'hFFFF00);
        bus(1'b0, 9'h194, 32'h0, q);
        check("fs flags", q[2:1], 32'h1);
        pins(1'b1, 1'b0, 1'b1, 1'b0);
        check("fs map b", on_w, 32'h0000FF);
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        bus(1'b0, 9'h100, 32'h0, q);
        check("fs current", q, 32'h2A);
        bus(1'b0, 9'h000, 32'h0, q);
        check("fs high", q, 32'h3C);
        bus(1'b0, 9'h080, 32'h0, q);
        check("fs low", q, 32'h5);
        bus(1'b0, 9'h188, 32'h0, q);
        check("fs config", {q[7:4], q[0]}, 32'h13);
        bus(1'b1, 9'h188, 32'h10A, q);
        check("fs phase", phase, 32'h1);
        pins(1'b1, 1'b0, 1'b0, 1'b1);
        check("fault", {lowcur, fpin}, 32'h3);
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        check("low current", lowcur, 32'h1);
        conclude();
    end
endmodule // test_led_dimming_failsafe_adc_ctrl

bind ldf_dimming_ctrl ldf_dimming_ctrl_props u_props (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .failsafe_active_in(failsafe_active_in),
    .failsafe_input_a_in(failsafe_input_a_in), .failsafe_input_b_in(failsafe_input_b_in),
    .fault_event_in(fault_event_in), .fault_pin_out(fault_pin_out), .low_current_mode_out(low_current_mode_out),
    .channel_output_on_out(channel_output_on_out), .conv_start_out(conv_start_out));
